// ---- module_disable_defs.svh ----
`ifndef MODULE_DISABLE_DEFS_SVH
`define MODULE_DISABLE_DEFS_SVH
// register byte offsets on the bus
`define MD_CTRL0_OFFSET 4'h0
`define MD_STATUS_OFFSET 4'h4
// field positions in the first disable register
`define MD_BIT_PIN_CHANGE 0
`define MD_BIT_CLOCK_REF 1
`define MD_BIT_NONVOLATILE 2
`define MD_BIT_SCANNER 3
`define MD_BIT_CHECKSUM 4
`define MD_BIT_VOLT_REF 6
`define MD_BIT_CLOCK_GATE 7
// writable bits; bit 5 is unimplemented
`define MD_CTRL0_MASK 8'hDF
`define MD_CTRL0_RESET 8'h00
// re-enable settle time
`define MD_INSTR_CYCLE_NS 125
`define MD_NVM_SETTLE_NS 1000
`define MD_CLK_PERIOD_NS 25
`endif

// ---- module_disable_pkg.sv ----
package module_disable_pkg;
  typedef enum logic [1:0] {
    UNIT_ON,
    UNIT_OFF,
    UNIT_WAKE
  } unit_state_t;
endpackage

// ---- peripheral_module_disable.sv ----
`timescale 1ns/1ps
`include "module_disable_defs.svh"
// How it works
// RULE_01: every disable bit clears on reset, so all units start enabled.
// RULE_02: a disabled unit gets no clock enable and no control strobes.
// RULE_03: a disabled unit is held in reset.
// RULE_04: unit register writes dropped, reads return zero while disabled.
// RULE_05: a disabled unit's pin outputs release to next priority owner.
// RULE_06: clearing the bit returns the unit in reset-value state.
// RULE_07: a re-enabled unit may need one instruction cycle to go active.
// RULE_08: software waits one instruction before touching a re-enabled unit.
// RULE_09: a disabled unit's input selection registers are disabled too.
// RULE_10: bit 7 gates the peripheral system clock network.
// RULE_11: bits 6,4,3,1,0 disable their units; bit 5 reads zero.
// RULE_12: bit 2 blocks memory access, memory control writes, pointer reads zero.
// RULE_13: software waits up to 1 us after memory re-enable before data access.
module peripheral_module_disable #(
  parameter int NUM_UNITS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // per-unit gating, index = bit position of the control register
  output logic [NUM_UNITS-1:0] unit_clk_en_o,
  output logic [NUM_UNITS-1:0] unit_reset_o,
  output logic [NUM_UNITS-1:0] unit_out_en_o,
  output logic [NUM_UNITS-1:0] unit_insel_en_o,
  output logic periph_clk_en_o,
  // unit register access path from the core
  input wire logic [NUM_UNITS-1:0] unit_sel_i,
  input wire logic unit_wr_i,
  input wire logic [7:0] unit_rdata_i,
  output logic [NUM_UNITS-1:0] unit_wr_o,
  output logic [7:0] unit_rdata_o,
  // non-volatile memory path
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic mem_ctrl_wr_i,
  input wire logic ptr_rd_i,
  input wire logic [7:0] mem_rdata_i,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic mem_ctrl_wr_o,
  output logic [7:0] mem_rdata_o,
  // pin ownership: pin wanted by this unit and by next in priority
  input wire logic [NUM_UNITS-1:0] unit_pin_out_i,
  input wire logic next_pin_out_i,
  output logic pin_out_o
);
  import module_disable_pkg::*;

  localparam int INSTR_CYCLES = (`MD_INSTR_CYCLE_NS + `MD_CLK_PERIOD_NS - 1) / `MD_CLK_PERIOD_NS;
  localparam int NVM_CYCLES = `MD_NVM_SETTLE_NS / `MD_CLK_PERIOD_NS;

  logic [7:0] ctrl0_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [NUM_UNITS-1:0] active;
  logic [NUM_UNITS-1:0] off_bits;
  logic req;

  function automatic logic hits(input logic [3:0] a, input logic [3:0] off);
    hits = a == off;
  endfunction

  assign req = cyc_i && stb_i && !ack_reg;
  assign off_bits = NUM_UNITS'(ctrl0_reg & `MD_CTRL0_MASK);

  // control register; only the low byte lane carries it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl0_reg <= `MD_CTRL0_RESET; // see RULE_01
    end else if (req && we_i && sel_i[0] && hits(adr_i, `MD_CTRL0_OFFSET)) begin
      ctrl0_reg <= dat_i[7:0] & `MD_CTRL0_MASK; // see RULE_11
    end
  end

  // single-cycle ack; unmapped addresses still ack and read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      dat_reg <= 32'h0000_0000;
      if (req && !we_i) begin
        if (hits(adr_i, `MD_CTRL0_OFFSET)) dat_reg <= {24'h00_0000, ctrl0_reg};
        else if (hits(adr_i, `MD_STATUS_OFFSET)) dat_reg <= {24'h00_0000, 8'(active)};
      end
    end
  end
  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // one gate per control bit; memory unit waits longer to settle
  genvar g;
  generate
    for (g = 0; g < NUM_UNITS; g++) begin : gen_unit
      localparam int WAKE = (g == `MD_BIT_NONVOLATILE) ? NVM_CYCLES : INSTR_CYCLES;
      unit_gate #(.WAKE_CYCLES(WAKE)) u_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .off_i(off_bits[g]),
        .state_o(),
        .clk_en_o(unit_clk_en_o[g]),
        .reset_o(unit_reset_o[g]),
        .active_o(active[g])
      );
    end
  endgenerate

  // outputs and input selection drop with the disable bit
  assign unit_out_en_o = ~off_bits; // see RULE_05
  assign unit_insel_en_o = ~off_bits; // see RULE_09
  assign pin_out_o = |(unit_pin_out_i & ~off_bits) ? 1'b1 : (|(unit_pin_out_i & off_bits) ? next_pin_out_i :
    next_pin_out_i); // see RULE_05
  assign periph_clk_en_o = !ctrl0_reg[`MD_BIT_CLOCK_GATE]; // see RULE_10

  // register writes blocked while off, reads blanked
  assign unit_wr_o = unit_wr_i ? (unit_sel_i & ~off_bits) : '0; // see RULE_04
  assign unit_rdata_o = |(unit_sel_i & off_bits) ? 8'h00 : unit_rdata_i; // see RULE_04

  // memory path; pointer reads of blocked memory give zero
  assign mem_rd_o = mem_rd_i && !off_bits[`MD_BIT_NONVOLATILE]; // see RULE_12
  assign mem_wr_o = mem_wr_i && !off_bits[`MD_BIT_NONVOLATILE]; // see RULE_12
  assign mem_ctrl_wr_o = mem_ctrl_wr_i && !off_bits[`MD_BIT_NONVOLATILE]; // see RULE_12
  assign mem_rdata_o = (off_bits[`MD_BIT_NONVOLATILE] && (ptr_rd_i || mem_rd_i)) ? 8'h00 : mem_rdata_i; // see RULE_12

  a_reset_all_on: assert property (@(posedge clk_i) // see RULE_01
    rst_i |=> ctrl0_reg == 8'h00) else $error("control not cleared by reset");
  a_read_blank: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_04
    |(unit_sel_i & off_bits) |-> unit_rdata_o == 8'h00 && unit_wr_o == '0) else $error("disabled unit reached");
  a_clock_gate: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_10
    ctrl0_reg[7] |-> !periph_clk_en_o) else $error("peripheral clock not gated");
  a_bit5_zero: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_11
    ack_reg && hits($past(adr_i), 4'h0) |-> dat_o[5] == 1'b0) else $error("bit 5 read nonzero");
  a_mem_block: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_12
    off_bits[2] |-> !mem_wr_o && !mem_ctrl_wr_o && !mem_rd_o) else $error("memory access not blocked");
  a_out_release: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_05
    off_bits != '0 |-> (unit_out_en_o & off_bits) == '0 && (unit_insel_en_o & off_bits) == '0)
    else $error("outputs of disabled unit still enabled");
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o ##1 !ack_o) else $error("ack not single cycle");
  a_reset_held: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_03
    off_bits != '0 |-> (unit_reset_o & off_bits) == off_bits) else $error("disabled unit out of reset");
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "module_disable_defs.svh"
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, unit_wr_i = 1'b0;
  logic mem_rd_i = 1'b1, mem_wr_i = 1'b1, mem_ctrl_wr_i = 1'b1, ptr_rd_i = 1'b1, next_pin_out_i = 1'b0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic ack_o, periph_clk_en_o, pin_out_o, mem_rd_o, mem_wr_o, mem_ctrl_wr_o;
  logic [7:0] unit_clk_en_o, unit_reset_o, unit_out_en_o, unit_insel_en_o, unit_wr_o, unit_rdata_o, mem_rdata_o;
  logic [7:0] unit_sel_i = 8'h01, unit_pin_out_i = 8'hDF, unit_rdata_i, mem_rdata_i = 8'h3C;
  int error_cnt = 0, checks_done = 0, cyc_cnt = 0;
  peripheral_module_disable peripheral_module_disable_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .unit_clk_en_o, .unit_reset_o, .unit_out_en_o, .unit_insel_en_o,
    .periph_clk_en_o, .unit_sel_i, .unit_wr_i, .unit_rdata_i, .unit_wr_o, .unit_rdata_o, .mem_rd_i,
    .mem_wr_i, .mem_ctrl_wr_i, .ptr_rd_i, .mem_rdata_i, .mem_rd_o, .mem_wr_o, .mem_ctrl_wr_o,
    .mem_rdata_o, .unit_pin_out_i, .next_pin_out_i, .pin_out_o);
  unit_model unit_model_i (.clk_i, .rst_i, .unit_reset_i(unit_reset_o), .unit_wr_i(unit_wr_o),
    .unit_sel_i, .unit_rdata_o(unit_rdata_i));
  // free-running clock, 25 ns period
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // single classic cycle; wait for ack with no assumed latency
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  // hang guard, well above the roughly one hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `MD_CTRL0_OFFSET, 8'h00, 4'hF);
    `CHK("ctrl after reset", 32'h0, rd)
    `CHK("clock enables", 8'hFF, unit_clk_en_o)
    unit_wr_i <= 1'b1;
    @(posedge clk_i);
    unit_wr_i <= 1'b0;
    @(posedge clk_i);
    `CHK("unit read enabled", 8'hA5, unit_rdata_o)
    // lane 0 off and an unmapped address: both must leave ctrl alone
    wb(1'b1, `MD_CTRL0_OFFSET, 8'hFF, 4'hE);
    wb(1'b1, 4'h8, 8'hFF, 4'hF);
    wb(1'b0, 4'h8, 8'h00, 4'hF);
    `CHK("unmapped read", 32'h0, rd)
    wb(1'b0, `MD_CTRL0_OFFSET, 8'h00, 4'hF);
    `CHK("ctrl unchanged", 32'h0, rd)
    wb(1'b1, `MD_CTRL0_OFFSET, 8'hFF, 4'hF);
    unit_wr_i <= 1'b1;
    wb(1'b0, `MD_CTRL0_OFFSET, 8'h00, 4'hF);
    `CHK("ctrl readback", 32'hDF, rd)
    `CHK("clk gated", 8'h00, unit_clk_en_o & 8'hDF)
    `CHK("held reset", 8'hDF, unit_reset_o & 8'hDF)
    `CHK("outputs off", 8'h00, unit_out_en_o & 8'hDF)
    `CHK("pin to next", 1'b0, pin_out_o)
    `CHK("insel off", 8'h00, unit_insel_en_o & 8'hDF)
    `CHK("periph clk", 1'b0, periph_clk_en_o)
    `CHK("unit write", 8'h00, unit_wr_o)
    `CHK("unit read", 8'h00, unit_rdata_o)
    `CHK("mem path", 4'h0, {mem_rd_o, mem_wr_o, mem_ctrl_wr_o, |mem_rdata_o})
    unit_wr_i <= 1'b0;
    wb(1'b0, `MD_STATUS_OFFSET, 8'h00, 4'hF);
    `CHK("status while off", 32'h20, rd)
    wb(1'b1, `MD_CTRL0_OFFSET, 8'h00, 4'hF);
    // software keeps away for seven clocks, more than one instruction, after re-enable
    repeat (7) @(posedge clk_i);
    `CHK("awake", 8'h00, unit_reset_o & 8'h5B)
    `CHK("fresh unit", 8'h00, unit_rdata_o)
    `CHK("periph clk on", 1'b1, periph_clk_en_o)
    `CHK("pin owner", 1'b1, pin_out_o)
    repeat (45) @(posedge clk_i);
    `CHK("mem awake", 1'b0, unit_reset_o[`MD_BIT_NONVOLATILE])
    `CHK("mem data", 8'h3C, mem_rdata_o)
    `CHK("outputs back", 8'hFF, unit_out_en_o & unit_insel_en_o)
    wb(1'b0, `MD_STATUS_OFFSET, 8'h00, 4'hF);
    `CHK("status all on", 32'hFF, rd)
    wrap_up();
  end
endmodule

// ---- unit_gate.sv ----
`timescale 1ns/1ps
`include "module_disable_defs.svh"
module unit_gate #(
  parameter int WAKE_CYCLES = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic off_i,
  output module_disable_pkg::unit_state_t state_o,
  output logic clk_en_o,
  output logic reset_o,
  output logic active_o
);
  import module_disable_pkg::*;
  unit_state_t state_reg;
  logic [7:0] wake_reg;

  // off forces reset; clear goes through a wake wait before active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= UNIT_ON;
      wake_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        UNIT_ON: begin
          if (off_i) state_reg <= UNIT_OFF;
        end
        UNIT_OFF: begin
          wake_reg <= 8'h00;
          if (!off_i) state_reg <= UNIT_WAKE;
        end
        UNIT_WAKE: begin
          if (off_i) begin
            state_reg <= UNIT_OFF;
          end else if (wake_reg == 8'(WAKE_CYCLES - 1)) begin // see RULE_07
            state_reg <= UNIT_ON;
          end else begin
            wake_reg <= wake_reg + 8'h01;
          end
        end
      endcase
    end
  end

  assign state_o = state_reg;
  // clock stops and reset holds while off, no toggling inside
  assign clk_en_o = !off_i && state_reg != UNIT_OFF; // see RULE_02
  assign reset_o = off_i || state_reg != UNIT_ON; // see RULE_03 see RULE_06
  assign active_o = state_reg == UNIT_ON && !off_i;

  a_off_holds_reset: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_03
    off_i |-> reset_o && !clk_en_o) else $error("disabled unit not held in reset");
  a_wake_bounded: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_07
    $fell(off_i) |-> ##[1:258] active_o) else $error("unit did not wake in time");
endmodule

// ---- unit_model.sv ----
`timescale 1ns/1ps
module unit_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] unit_reset_i,
  input wire logic [7:0] unit_wr_i,
  input wire logic [7:0] unit_sel_i,
  output logic [7:0] unit_rdata_o
);
  logic [7:0] touched_reg;
  // a write marks the unit; its reset drops the mark back to the power-on value
  always_ff @(posedge clk_i) begin
    if (rst_i)
      touched_reg <= 8'h00;
    else
      touched_reg <= (touched_reg | unit_wr_i) & ~unit_reset_i;
  end
  // selected unit shows a marker once written, zero when fresh
  assign unit_rdata_o = |(unit_sel_i & touched_reg) ? 8'hA5 : 8'h00;
endmodule
